/* src/id_prom_consts.vh */
// Constants for the two-wire identification PROM slave.
// Assumes a 25 MHz system clock; included by bare name.
`ifndef ID_PROM_CONSTS_VH
`define ID_PROM_CONSTS_VH
`define CLK_HZ            25000000
`define WRITE_CYCLE_MS    5
`define WRITE_CYCLE_CYC   ((`CLK_HZ / 1000) * `WRITE_CYCLE_MS)
`define CMD_MSB           7
`define CMD_LSB           6
`define ADDR_MSB          5
`define ADDR_LSB          2
`define CMD_READ          2'h2
`define CMD_PROGRAM       2'h1
`define ARRAY_DEPTH       16
`define ARRAY_RESET_BYTE  8'hff
`endif

/* src/line_sync.v */
// Two-flop synchroniser with edge detection for one pin input.
// Assumes the input is asynchronous to sys_clk.
`timescale 1ns/1ns
module line_sync (
   input  wire sys_clk,
   input  wire reset,
   input  wire pin,
   output reg  level,
   output wire rise,
   output wire fall
);
   reg meta;
   reg last;

   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         meta  <= 1'b1;
         level <= 1'b1;
         last  <= 1'b1;
      end else begin
         meta  <= pin;
         level <= meta;
         last  <= level;
      end
   end

   assign rise = level & ~last;
   assign fall = ~level & last;
endmodule

/* src/serial_id_prom_slave.v */
// Two-wire slave of a 16 x 8 identification PROM, sampled by sys_clk.
// Assumes the master drives the serial clock well below sys_clk / 4 and
// resolves the data wire from data_out and data_oe.
`timescale 1ns/1ns
`include "id_prom_consts.vh"

module serial_id_prom_slave #(
   parameter WRITE_CYCLES = `WRITE_CYCLE_CYC
) (
   input  wire       sys_clk,
   input  wire       reset,
   input  wire       serial_clk,
   input  wire       program_enable_voltage,
   input  wire       data_in,
   output reg        data_out,
   output reg        data_oe,
   output wire       busy_writing,
   output wire [1:0] bus_state
);
   localparam ST_IDLE  = 3'h0;
   localparam ST_CMD   = 3'h1;
   localparam ST_PDATA = 3'h2;
   localparam ST_READ  = 3'h3;
   localparam ST_WRITE = 3'h4;

   reg  [2:0]  state;
   reg  [2:0]  next_state;
   reg  [2:0]  bit_count;
   reg  [7:0]  shift;
   reg  [3:0]  address;
   reg         prog_mode;
   reg  [22:0] write_timer;
   reg  [7:0]  array [0:`ARRAY_DEPTH-1];
   reg  [1:0]  vpgm_meta;
   reg         vpgm;

   wire        scl;
   wire        scl_rise;
   wire        scl_fall;
   wire        sda;
   wire        sda_rise;
   wire        sda_fall;
   wire        start_seen;
   wire        stop_seen;
   wire        input_phase;
   wire        last_cmd_bit;
   wire [7:0]  shifted;

   line_sync clk_sync (
      .sys_clk (sys_clk),
      .reset   (reset),
      .pin     (serial_clk),
      .level   (scl),
      .rise    (scl_rise),
      .fall    (scl_fall)
   );

   line_sync data_sync (
      .sys_clk (sys_clk),
      .reset   (reset),
      .pin     (data_in),
      .level   (sda),
      .rise    (sda_rise),
      .fall    (sda_fall)
   );

   // The high-voltage flag is a level, so a plain three-flop crossing
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         vpgm_meta <= 2'h0;
         vpgm      <= 1'b0;
      end else begin
         vpgm_meta <= {vpgm_meta[0], program_enable_voltage};
         vpgm      <= vpgm_meta[1];
      end
   end

   // Data edges with the clock high are framing, never data
   assign start_seen   = scl & sda_fall;
   assign stop_seen    = scl & sda_rise;
   assign input_phase  = (state == ST_CMD) | (state == ST_PDATA);
   // During the final command bit the master releases the wire, so its
   // wiggles must not be taken for framing
   assign last_cmd_bit = (state == ST_CMD) & (bit_count == 3'h7);
   assign shifted      = {shift[6:0], sda};
   assign busy_writing = (state == ST_WRITE);
   assign bus_state    = {state == ST_READ, input_phase};

   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (start_seen) begin
               next_state = ST_CMD;
            end
         end
         ST_CMD, ST_PDATA: begin
            if (scl_rise & (bit_count == 3'h7)) begin
               if (state == ST_PDATA) begin
                  next_state = ST_WRITE;
               end else if (prog_mode & (shifted[`CMD_MSB:`CMD_LSB] == `CMD_PROGRAM)) begin
                  next_state = ST_PDATA;
               end else if (~prog_mode & (shifted[`CMD_MSB:`CMD_LSB] == `CMD_READ)) begin
                  next_state = ST_READ;
               end else begin
                  next_state = ST_IDLE;
               end
            end else if (start_seen & ~last_cmd_bit) begin
               next_state = ST_CMD;
            end else if (stop_seen & ~last_cmd_bit) begin
               next_state = ST_IDLE;
            end
         end
         ST_READ: begin
            // Framing is ignored here; the push-pull driver owns the wire
            if (scl_fall & (bit_count == 3'h0) & ~data_oe) begin
               next_state = ST_READ;
            end else if (scl_fall & (bit_count == 3'h7) & data_oe) begin
               next_state = ST_IDLE;
            end
         end
         ST_WRITE: begin
            if (write_timer == 23'h0) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // Array contents are not kept over reset in this model; reset fills it
   // with the erased value since no non-volatile cell exists here
   genvar i;
   generate
      for (i = 0; i < `ARRAY_DEPTH; i = i + 1) begin : cells
         always @(posedge sys_clk or posedge reset) begin
            if (reset) begin
               array[i] <= `ARRAY_RESET_BYTE;
            end else if ((state == ST_PDATA) & scl_rise & (bit_count == 3'h7) & (address == i)) begin
               array[i] <= shifted;
            end
         end
      end
   endgenerate

   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state       <= ST_IDLE;
         bit_count   <= 3'h0;
         shift       <= 8'h00;
         address     <= 4'h0;
         prog_mode   <= 1'b0;
         write_timer <= 23'h0;
         data_out    <= 1'b0;
         data_oe     <= 1'b0;
      end else begin
         state <= next_state;
         case (state)
            ST_IDLE: begin
               bit_count <= 3'h0;
               data_oe   <= 1'b0;
               if (start_seen) begin
                  prog_mode <= vpgm;
               end
            end
            ST_CMD, ST_PDATA: begin
               if (next_state == ST_CMD && start_seen && ~last_cmd_bit) begin
                  bit_count <= 3'h0;
                  prog_mode <= vpgm;
               end else if (next_state == ST_IDLE && !scl_rise) begin
                  bit_count <= 3'h0;
                  prog_mode <= 1'b0;
               end else if (scl_rise) begin
                  // Mode stays latched whatever the clock's high level
                  bit_count <= bit_count + 3'h1;
                  shift     <= shifted;
                  if ((state == ST_CMD) & (bit_count == 3'h7)) begin
                     address <= shifted[`ADDR_MSB:`ADDR_LSB];
                     // Load the addressed byte ready for output
                     shift   <= array[shifted[`ADDR_MSB:`ADDR_LSB]];
                  end
                  if ((state == ST_PDATA) & (bit_count == 3'h7)) begin
                     write_timer <= WRITE_CYCLES[22:0] - 23'h1;
                  end
               end
               data_oe <= 1'b0;
            end
            ST_READ: begin
               if (scl_fall) begin
                  // First falling edge opens the driver with the MSB
                  if (~data_oe) begin
                     data_oe  <= ~prog_mode;
                     data_out <= shift[7];
                     shift    <= {shift[6:0], 1'b0};
                  end else if (bit_count == 3'h7) begin
                     data_oe   <= 1'b0;
                     bit_count <= 3'h0;
                     prog_mode <= 1'b0;
                  end else begin
                     data_out  <= shift[7];
                     shift     <= {shift[6:0], 1'b0};
                     bit_count <= bit_count + 3'h1;
                  end
               end
            end
            ST_WRITE: begin
               data_oe   <= 1'b0;
               bit_count <= 3'h0;
               prog_mode <= 1'b0;
               if (write_timer != 23'h0) begin
                  write_timer <= write_timer - 23'h1;
               end
            end
            default: begin
               data_oe <= 1'b0;
            end
         endcase
      end
   end
   // The clock pin is input only; the block has no clock driver at all
endmodule

/* test/wire_master.sv */
// Behavioural two-wire bus master for the PROM slave pins.
// Assumes sys_clk at 25 MHz; serial clock of 8 sys_clk, held still between frames.
`timescale 1ns/1ns
module wire_master (
   input  wire sys_clk,
   input  wire data_out,
   input  wire data_oe,
   output reg  serial_clk,
   output reg  program_enable_voltage,
   output wire sda
);
   reg m_sda = 1'b1;
   reg m_oe  = 1'b1;
   reg last  = 1'b1;
   initial begin
      serial_clk = 1'b1;
      program_enable_voltage = 1'b0;
   end
   // A freed wire shows the inverse of its last level, not a lucky one
   assign sda = data_oe ? data_out : (m_oe ? m_sda : ~last);
   always @(posedge sys_clk) last <= sda;
   task tick(input integer n);
      repeat (n) @(posedge sys_clk);
   endtask
   // Start when first is set, stop otherwise; data is set with clock low, then flips with clock high
   task cond(input reg first, input reg hv);
      tick(1);
      serial_clk <= 1'b0;
      m_oe <= 1'b1;
      tick(2);
      m_sda <= first;
      program_enable_voltage <= hv;
      tick(2);
      serial_clk <= 1'b1;
      tick(4);
      m_sda <= ~first;
      tick(4);
      if (first) serial_clk <= 1'b0;
   endtask
   task send(input [7:0] b, input integer n);
      integer i;
      for (i = 7; i > 7 - n; i = i - 1) begin
         tick(1);
         m_sda <= b[i];
         tick(3);
         serial_clk <= 1'b1;
         tick(4);
         serial_clk <= 1'b0;
      end
   endtask
   task recv(output [7:0] b);
      integer i;
      m_oe <= 1'b0;
      for (i = 0; i < 8; i = i + 1) begin
         tick(4);
         b = {b[6:0], sda};
         serial_clk <= 1'b1;
         tick(4);
         serial_clk <= 1'b0;
      end
      tick(6);
      m_oe <= 1'b1;
      m_sda <= 1'b1;
   endtask
endmodule

/* test/serial_id_prom_checker.sv */
// Port-level assertions for the PROM slave.
// Assumes binding to serial_id_prom_slave; one sys_clk domain.
`timescale 1ns/1ns
module serial_id_prom_checker #(
   parameter WRITE_CYCLES = 50
) (
   input wire       sys_clk,
   input wire       reset,
   input wire       serial_clk,
   input wire       program_enable_voltage,
   input wire       data_in,
   input wire       data_out,
   input wire       data_oe,
   input wire       busy_writing,
   input wire [1:0] bus_state
);
   integer   busy_cnt;
   reg [3:0] fall_cnt;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         busy_cnt <= 0;
         fall_cnt <= 4'h0;
      end else begin
         busy_cnt <= busy_writing ? busy_cnt + 1 : 0;
         if (!data_oe) fall_cnt <= 4'h0;
         else if ($fell(serial_clk)) fall_cnt <= fall_cnt + 4'h1;
      end
   end
   a_busy_no_drive: assert property (busy_writing |-> !data_oe) else $error("driven while busy");
   a_busy_length: assert property ($fell(busy_writing) |-> busy_cnt == WRITE_CYCLES)
      else $error("write cycle length");
   a_prog_no_drive: assert property (program_enable_voltage |-> !data_oe) else $error("driven in program");
   a_oe_reading: assert property (data_oe |-> bus_state[1]) else $error("driven outside read");
   a_out_stable: assert property (serial_clk && $past(serial_clk) && data_oe && $past(data_oe)
      |-> $stable(data_out)) else $error("data moved with clock high");
   a_oe_after_fall: assert property ($rose(data_oe) |-> !serial_clk) else $error("output began high");
   a_eight_bits: assert property ($fell(data_oe) |-> fall_cnt == 4'h8) else $error("read bit count");
   a_read_standby: assert property ($fell(data_oe) |-> bus_state == 2'b00) else $error("no standby");
   a_write_after_data: assert property ($rose(busy_writing) |-> $past(bus_state[0]))
      else $error("write without input");
   cover property ($fell(data_oe));
   cover property ($fell(busy_writing));
   cover property ($rose(bus_state[0]));
endmodule
bind serial_id_prom_slave serial_id_prom_checker #(.WRITE_CYCLES(WRITE_CYCLES)) i_checker (
   .sys_clk(sys_clk), .reset(reset), .serial_clk(serial_clk), .program_enable_voltage(program_enable_voltage),
   .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .busy_writing(busy_writing), .bus_state(bus_state));

/* test/tb_top.sv */
// Self-checking bench for the PROM slave with a behavioural master.
// Assumes the short write cycle of 50 sys_clk.
`timescale 1ns/1ns
module tb_top;
   reg        sys_clk   = 1'b0;
   reg        reset     = 1'b1;
   wire       serial_clk, program_enable_voltage, sda, data_out, data_oe, busy_writing;
   wire [1:0] bus_state;
   integer    error_cnt = 0;
   integer    n_checks  = 0;
   integer    i;
   reg [7:0]  got;
   reg [12:0] rows [0:4];
   initial begin
      forever #20 sys_clk = ~sys_clk;
   end
   serial_id_prom_slave #(.WRITE_CYCLES(50)) i_serial_id_prom_slave (.sys_clk(sys_clk), .reset(reset),
      .serial_clk(serial_clk), .program_enable_voltage(program_enable_voltage), .data_in(sda),
      .data_out(data_out), .data_oe(data_oe), .busy_writing(busy_writing), .bus_state(bus_state));
   wire_master i_wire_master (.sys_clk(sys_clk), .data_out(data_out), .data_oe(data_oe),
      .serial_clk(serial_clk), .program_enable_voltage(program_enable_voltage), .sda(sda));
   task chk(input [7:0] g, input [7:0] e);
      n_checks = n_checks + 1;
      if (g !== e) begin
         error_cnt = error_cnt + 1;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task wrap_up;
      $display("checks=%0d errors=%0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task rd(input [3:0] a);
      i_wire_master.cond(1'b1, 1'b0);
      i_wire_master.send({2'b10, a, 2'b00}, 8);
      i_wire_master.recv(got);
   endtask
   initial begin
      // Row: high-voltage flag, address, data; a row without the voltage must store nothing
      rows[0] = 13'h10a5;
      rows[1] = 13'h1f5a;
      rows[2] = 13'h193c;
      rows[3] = 13'h1000;
      rows[4] = 13'h0bcc;
      repeat (8) @(posedge sys_clk);
      reset <= 1'b0;
      i_wire_master.tick(4);
      chk({bus_state, data_oe, busy_writing}, 8'h00);
      i_wire_master.send(8'h9c, 8);
      i_wire_master.tick(6);
      chk({bus_state, data_oe}, 8'h00);
      rd(4'h7);
      chk(got, 8'hff);
      for (i = 0; i < 5; i = i + 1) begin
         i_wire_master.cond(1'b1, rows[i][12]);
         i_wire_master.send({2'b01, rows[i][11:8], 2'b00}, 8);
         // Voltage drops mid-operation; programming must carry on
         i_wire_master.program_enable_voltage <= 1'b0;
         i_wire_master.send(rows[i][7:0], 8);
         i_wire_master.tick(4);
         chk(busy_writing, rows[i][12]);
         i_wire_master.cond(1'b0, 1'b0);
         chk(busy_writing, rows[i][12]);
         i_wire_master.tick(60);
         chk(busy_writing, 1'b0);
         rd(rows[i][11:8]);
         chk(got, rows[i][12] ? rows[i][7:0] : 8'hff);
      end
      i_wire_master.cond(1'b1, 1'b0);
      i_wire_master.send(8'hff, 4);
      rd(4'hf);
      chk(got, 8'h5a);
      i_wire_master.cond(1'b1, 1'b0);
      i_wire_master.send(8'h80, 5);
      i_wire_master.cond(1'b0, 1'b0);
      i_wire_master.tick(4);
      chk(bus_state, 2'b00);
      i_wire_master.cond(1'b1, 1'b0);
      i_wire_master.send(8'hc0, 8);
      i_wire_master.tick(8);
      chk({bus_state, data_oe}, 8'h00);
      i_wire_master.cond(1'b1, 1'b0);
      i_wire_master.send(8'h44, 8);
      i_wire_master.send(8'h11, 8);
      i_wire_master.tick(4);
      chk(busy_writing, 1'b0);
      rd(4'h1);
      chk(got, 8'hff);
      // Framing wiggles around the last control bit must not disturb the read
      i_wire_master.cond(1'b1, 1'b0);
      i_wire_master.send(8'hbc, 7);
      i_wire_master.tick(1);
      i_wire_master.serial_clk <= 1'b1;
      i_wire_master.tick(2);
      i_wire_master.m_sda <= 1'b1;
      i_wire_master.tick(2);
      i_wire_master.m_sda <= 1'b0;
      i_wire_master.tick(2);
      i_wire_master.serial_clk <= 1'b0;
      i_wire_master.recv(got);
      chk(got, 8'h5a);
      // Reset just after the read driver opens, with only the first bit out
      i_wire_master.cond(1'b1, 1'b0);
      i_wire_master.send(8'hbc, 8);
      i_wire_master.tick(6);
      chk(data_oe, 1'b1);
      reset <= 1'b1;
      i_wire_master.tick(2);
      chk({bus_state, data_oe, busy_writing}, 8'h00);
      reset <= 1'b0;
      i_wire_master.tick(4);
      rd(4'hf);
      chk(got, 8'hff);
      wrap_up;
   end
   initial begin
      repeat (50000) @(posedge sys_clk);
      error_cnt = error_cnt + 1;
      wrap_up;
   end
endmodule
